// ===== design/tfr_pkg.sv
// Purpose: shared constants of the temperature and fan reading register bank
// Assumes: byte-wide registers addressed by an 8-bit pointer on the serial management bus
// Notes: limits hold the upper eight bits of an 11-bit two's complement value
package tfr_pkg;

	// register pointers
	localparam logic [7:0] TFR_TEMP_LOW_BITS = 8'h06;
	localparam logic [7:0] TFR_FAN_PERIOD_LOW = 8'h08;
	localparam logic [7:0] TFR_FAN_PERIOD_HIGH = 8'h09;
	localparam logic [7:0] TFR_LOCAL_TEMP_HIGH = 8'h0A;
	localparam logic [7:0] TFR_REMOTE_TEMP_HIGH = 8'h0B;
	localparam logic [7:0] TFR_LOCAL_UPPER_BOUND = 8'h14;
	localparam logic [7:0] TFR_LOCAL_LOWER_BOUND = 8'h15;
	localparam logic [7:0] TFR_LOCAL_OVERHEAT = 8'h16;
	localparam logic [7:0] TFR_REMOTE_UPPER_BOUND = 8'h18;
	localparam logic [7:0] TFR_REMOTE_LOWER_BOUND = 8'h19;
	localparam logic [7:0] TFR_REMOTE_OVERHEAT = 8'h1A;
	localparam logic [7:0] TFR_LOCAL_CRITICAL = 8'h1B;
	localparam logic [7:0] TFR_PASSIVE_COOLING = 8'h1C;
	localparam logic [7:0] TFR_REMOTE_CRITICAL = 8'h1D;
	localparam logic [7:0] TFR_TARGET_PERIOD_LOW = 8'h1E;
	localparam logic [7:0] TFR_TARGET_PERIOD_HIGH = 8'h1F;

	// reset values
	localparam logic [7:0] TFR_RST_TEMP_HIGH = 8'h80;
	localparam logic [2:0] TFR_RST_TEMP_LSBS = 3'h0;
	localparam logic [15:0] TFR_RST_FAN_PERIOD = 16'h0000;
	localparam logic [7:0] TFR_RST_LOCAL_UPPER = 8'h3C;
	localparam logic [7:0] TFR_RST_LOCAL_LOWER = 8'h00;
	localparam logic [7:0] TFR_RST_LOCAL_OVERHEAT = 8'h46;
	localparam logic [7:0] TFR_RST_LOCAL_CRITICAL = 8'h50;
	localparam logic [7:0] TFR_RST_REMOTE_UPPER = 8'h50;
	localparam logic [7:0] TFR_RST_REMOTE_LOWER = 8'h00;
	localparam logic [7:0] TFR_RST_REMOTE_OVERHEAT = 8'h64;
	localparam logic [7:0] TFR_RST_REMOTE_CRITICAL = 8'h69;
	localparam logic [5:0] TFR_RST_PASSIVE = 6'h00;
	localparam logic [7:0] TFR_RST_TARGET_BYTE = 8'hFF;
	localparam logic [7:0] TFR_RST_DUTY = 8'h00;
	localparam logic [7:0] TFR_UNMAPPED_READ = 8'h00;

	// field layout of the shared low temperature byte
	localparam int TFR_LOW_LOCAL_MSB = 7;
	localparam int TFR_LOW_LOCAL_LSB = 5;
	localparam int TFR_LOW_REMOTE_MSB = 2;
	localparam int TFR_LOW_REMOTE_LSB = 0;
	localparam logic [1:0] TFR_LOW_GAP = 2'h0;

	// temperature coding
	localparam int TFR_TEMP_BITS = 11;
	localparam int TFR_FRAC_BITS = 3;
	localparam int TFR_PASSIVE_BITS = 6;
	localparam logic [1:0] TFR_PASSIVE_TOP = 2'h0;

	// software speed loop dead band on the period difference
	localparam logic [15:0] TFR_SETTLE_WINDOW = 16'h000A;

	// serial bus framing
	localparam logic [3:0] TFR_BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] TFR_ACK_DONE = 4'h9;

endpackage : tfr_pkg

// ===== design/tfr_sync.sv
// Purpose: two-flop synchroniser for pins that come from outside the clock domain
// Assumes: pins idle high, so both stages reset to one
// Notes: only the second stage may be read by other logic
module tfr_sync #(
	parameter int W = 2
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] pin_sync
);

	logic [W-1:0] stage1;

	always_ff @(posedge mclk) begin
		if (srst) begin
			stage1 <= '1;
			pin_sync <= '1;
		end else begin
			stage1 <= pin;
			pin_sync <= stage1;
		end
	end

endmodule : tfr_sync

// ===== design/tfr_hold.sv
// Purpose: reading holder that can be frozen against new results
// Assumes: new_valid is a one-cycle pulse from core logic on mclk
// Notes: a result that arrives while frozen waits and lands once freeze drops
module tfr_hold #(
	parameter int W = 16,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic freeze,
	input wire logic new_valid,
	input wire logic [W-1:0] new_data,
	output logic [W-1:0] data
);

	logic pending;
	logic [W-1:0] pend_data;

	always_ff @(posedge mclk) begin
		if (srst) begin
			pending <= 1'b0;
			pend_data <= RST;
		end else if (new_valid && freeze) begin
			pending <= 1'b1;
			pend_data <= new_data;
		end else if (!freeze) begin
			pending <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			data <= RST;
		end else if (!freeze && new_valid) begin
			data <= new_data;
		end else if (!freeze && pending) begin
			data <= pend_data;
		end
	end

endmodule : tfr_hold

// ===== design/tfr_regs.sv
// Purpose: register bank for temperature readings, limits and fan period, reached over the serial management bus
// Assumes: conversion and tachometer results arrive on mclk from core logic; scl and sda come from pins
// Notes: byte-data protocol, one register per transfer, no clock stretching
//
// How it works
// - low byte: local bits 2..0 in 7..5, zeros, remote bits 2..0 in 2..0
// - local high byte holds local reading bits 10..3, resets to 0x80
// - remote high byte holds remote reading bits 10..3, resets to 0x80
// - high byte alone gives whole degrees; with low bits gives eighth degrees
// - high temperature bytes read alone never freeze anything
// - reading the low byte freezes all temperature readings until remote high read
// - each limit is 11 bits with three zero LSBs, eight bits stored
// - local upper bound resets to 0x3C, local lower bound to zero
// - local overheat resets to 0x46, local critical to 0x50
// - remote upper 0x50, overheat 0x64, critical 0x69, lower zero at reset
// - passive cooling register keeps six bits in 5..0, rest read zero
// - automatic loop forces duty to zero at or below passive threshold
// - fan period is 16 bits over two bytes, reset zero
// - reading fan period low byte freezes high byte until both read
// - host writes target period in two bytes, both reset to 0xFF
// - software speed mode holds duty while period difference is at most 0x000A
module tfr_regs
	import tfr_pkg::*;
#(
	parameter logic [6:0] BUS_ADDR = 7'h2C // arbitrary default
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic conv_valid,
	input wire logic [10:0] local_reading,
	input wire logic [10:0] remote_reading,
	input wire logic period_valid,
	input wire logic [15:0] period_count,
	input wire logic auto_temp_mode,
	input wire logic soft_speed_mode,
	input wire logic [10:0] active_temp,
	input wire logic duty_req_valid,
	input wire logic [7:0] duty_req,
	output logic [7:0] duty_cycle,
	output logic fan_stopped,
	output logic period_settled,
	output logic [7:0] local_upper_field,
	output logic [7:0] local_lower_field,
	output logic [7:0] local_overheat_field,
	output logic [7:0] local_critical_field,
	output logic [7:0] remote_upper_field,
	output logic [7:0] remote_lower_field,
	output logic [7:0] remote_overheat_field,
	output logic [7:0] remote_critical_field,
	output logic [5:0] passive_cooling_field,
	output logic [15:0] target_period
);

	typedef enum logic [2:0] {
		TFR_IDLE,
		TFR_ADDR,
		TFR_CMD,
		TFR_WRITE,
		TFR_READ,
		TFR_SKIP
	} tfr_phase_t;

	tfr_phase_t phase;
	logic [1:0] pins_sync;
	logic scl_q;
	logic sda_q;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] pointer;
	logic [7:0] rd_byte;
	logic rd_strobe;
	logic wr_strobe;
	logic [7:0] wr_byte;
	logic temp_freeze;
	logic fan_freeze;
	logic [21:0] temp_pair;
	logic [15:0] fan_period;
	logic [10:0] passive_limit;
	logic [15:0] period_diff;
	logic next_settled;

	// pin sampling
	tfr_sync #(
		.W(2)
	) u_sync (
		.mclk(mclk),
		.srst(srst),
		.pin({scl_in, sda_in}),
		.pin_sync(pins_sync)
	);

	assign scl_q = pins_sync[1];
	assign sda_q = pins_sync[0];

	always_ff @(posedge mclk) begin
		if (srst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_q;
			sda_d <= sda_q;
		end
	end

	assign scl_rise = scl_q && !scl_d;
	assign scl_fall = !scl_q && scl_d;
	assign bus_start = scl_q && scl_d && sda_d && !sda_q;
	assign bus_stop = scl_q && scl_d && !sda_d && sda_q;

	// bit counter: 0..7 data bits, 8 ack slot, 9 after ack
	always_ff @(posedge mclk) begin
		if (srst) begin
			bit_cnt <= '0;
		end else if (bus_start || bus_stop) begin
			bit_cnt <= '0;
		end else if (scl_rise && bit_cnt <= TFR_BITS_PER_BYTE) begin
			bit_cnt <= bit_cnt + 4'h1;
		end else if (scl_fall && bit_cnt == TFR_ACK_DONE) begin
			bit_cnt <= '0;
		end
	end

	// protocol phase
	always_ff @(posedge mclk) begin
		if (srst) begin
			phase <= TFR_IDLE;
		end else if (bus_start) begin
			phase <= TFR_ADDR;
		end else if (bus_stop) begin
			phase <= TFR_IDLE;
		end else if (scl_rise && bit_cnt == TFR_BITS_PER_BYTE && phase == TFR_READ && sda_q) begin
			phase <= TFR_SKIP;
		end else if (scl_fall && bit_cnt == TFR_BITS_PER_BYTE) begin
			unique case (phase)
				TFR_ADDR: begin
					if (shift[7:1] != BUS_ADDR) begin
						phase <= TFR_SKIP;
					end else if (shift[0]) begin
						phase <= TFR_READ;
					end else begin
						phase <= TFR_CMD;
					end
				end
				TFR_CMD: phase <= TFR_WRITE;
				TFR_IDLE, TFR_WRITE, TFR_READ, TFR_SKIP: phase <= phase;
			endcase
		end
	end

	// shift register: samples on rise while receiving, shifts out on fall while sending
	always_ff @(posedge mclk) begin
		if (srst) begin
			shift <= '0;
		end else if (scl_rise && bit_cnt < TFR_BITS_PER_BYTE && phase != TFR_READ) begin
			shift <= {shift[6:0], sda_q};
		end else if (rd_strobe) begin
			shift <= {rd_byte[6:0], 1'b0};
		end else if (scl_fall && phase == TFR_READ && bit_cnt != '0 && bit_cnt < TFR_BITS_PER_BYTE) begin
			shift <= {shift[6:0], 1'b0};
		end
	end

	// one read strobe per data byte sent, at the start of its first bit
	assign rd_strobe = scl_fall && bit_cnt == TFR_ACK_DONE && phase == TFR_READ;
	assign wr_strobe = scl_fall && bit_cnt == TFR_BITS_PER_BYTE && phase == TFR_WRITE;
	assign wr_byte = shift;

	always_ff @(posedge mclk) begin
		if (srst) begin
			pointer <= '0;
		end else if (scl_fall && bit_cnt == TFR_BITS_PER_BYTE && phase == TFR_CMD) begin
			pointer <= shift;
		end
	end

	// data line drive: ack after our address and written bytes, data while reading
	always_ff @(posedge mclk) begin
		if (srst) begin
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
		end else if (bus_start || bus_stop) begin
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
		end else if (scl_fall && bit_cnt == TFR_BITS_PER_BYTE) begin
			if ((phase == TFR_ADDR && shift[7:1] == BUS_ADDR) || phase == TFR_CMD || phase == TFR_WRITE) begin
				sda_out <= 1'b0;
				sda_oe <= 1'b1;
			end else begin
				sda_out <= 1'b1;
				sda_oe <= 1'b0;
			end
		end else if (rd_strobe) begin
			sda_out <= rd_byte[7];
			sda_oe <= !rd_byte[7];
		end else if (scl_fall && phase == TFR_READ && bit_cnt != '0 && bit_cnt < TFR_BITS_PER_BYTE) begin
			sda_out <= shift[7];
			sda_oe <= !shift[7];
		end else if (scl_fall) begin
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
		end
	end

	// freeze control; a set in the same cycle as a release wins
	always_ff @(posedge mclk) begin
		if (srst) begin
			temp_freeze <= 1'b0;
		end else if (rd_strobe && pointer == TFR_TEMP_LOW_BITS) begin
			temp_freeze <= 1'b1;
		end else if (rd_strobe && pointer == TFR_REMOTE_TEMP_HIGH) begin
			temp_freeze <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			fan_freeze <= 1'b0;
		end else if (rd_strobe && pointer == TFR_FAN_PERIOD_LOW) begin
			fan_freeze <= 1'b1;
		end else if (rd_strobe && pointer == TFR_FAN_PERIOD_HIGH) begin
			fan_freeze <= 1'b0;
		end
	end

	// newest readings, held while frozen and caught up afterwards
	tfr_hold #(
		.W(2 * TFR_TEMP_BITS),
		.RST({TFR_RST_TEMP_HIGH, TFR_RST_TEMP_LSBS, TFR_RST_TEMP_HIGH, TFR_RST_TEMP_LSBS})
	) u_temp_hold (
		.mclk(mclk),
		.srst(srst),
		.freeze(temp_freeze),
		.new_valid(conv_valid),
		.new_data({local_reading, remote_reading}),
		.data(temp_pair)
	);

	tfr_hold #(
		.W(16),
		.RST(TFR_RST_FAN_PERIOD)
	) u_fan_hold (
		.mclk(mclk),
		.srst(srst),
		.freeze(fan_freeze),
		.new_valid(period_valid),
		.new_data(period_count),
		.data(fan_period)
	);

	// read mux
	always_comb begin
		rd_byte = TFR_UNMAPPED_READ;
		unique case (pointer)
			TFR_TEMP_LOW_BITS: rd_byte = {temp_pair[13:11], TFR_LOW_GAP, temp_pair[2:0]};
			TFR_FAN_PERIOD_LOW: rd_byte = fan_period[7:0];
			TFR_FAN_PERIOD_HIGH: rd_byte = fan_period[15:8];
			TFR_LOCAL_TEMP_HIGH: rd_byte = temp_pair[21:14];
			TFR_REMOTE_TEMP_HIGH: rd_byte = temp_pair[10:3];
			TFR_LOCAL_UPPER_BOUND: rd_byte = local_upper_field;
			TFR_LOCAL_LOWER_BOUND: rd_byte = local_lower_field;
			TFR_LOCAL_OVERHEAT: rd_byte = local_overheat_field;
			TFR_REMOTE_UPPER_BOUND: rd_byte = remote_upper_field;
			TFR_REMOTE_LOWER_BOUND: rd_byte = remote_lower_field;
			TFR_REMOTE_OVERHEAT: rd_byte = remote_overheat_field;
			TFR_LOCAL_CRITICAL: rd_byte = local_critical_field;
			TFR_PASSIVE_COOLING: rd_byte = {TFR_PASSIVE_TOP, passive_cooling_field};
			TFR_REMOTE_CRITICAL: rd_byte = remote_critical_field;
			TFR_TARGET_PERIOD_LOW: rd_byte = target_period[7:0];
			TFR_TARGET_PERIOD_HIGH: rd_byte = target_period[15:8];
			default: rd_byte = TFR_UNMAPPED_READ;
		endcase
	end

	// limit registers: upper eight bits of 11-bit values
	always_ff @(posedge mclk) begin
		if (srst) begin
			local_upper_field <= TFR_RST_LOCAL_UPPER;
			local_lower_field <= TFR_RST_LOCAL_LOWER;
			local_overheat_field <= TFR_RST_LOCAL_OVERHEAT;
			local_critical_field <= TFR_RST_LOCAL_CRITICAL;
			remote_upper_field <= TFR_RST_REMOTE_UPPER;
			remote_lower_field <= TFR_RST_REMOTE_LOWER;
			remote_overheat_field <= TFR_RST_REMOTE_OVERHEAT;
			remote_critical_field <= TFR_RST_REMOTE_CRITICAL;
		end else if (wr_strobe) begin
			unique case (pointer)
				TFR_LOCAL_UPPER_BOUND: local_upper_field <= wr_byte;
				TFR_LOCAL_LOWER_BOUND: local_lower_field <= wr_byte;
				TFR_LOCAL_OVERHEAT: local_overheat_field <= wr_byte;
				TFR_LOCAL_CRITICAL: local_critical_field <= wr_byte;
				TFR_REMOTE_UPPER_BOUND: remote_upper_field <= wr_byte;
				TFR_REMOTE_LOWER_BOUND: remote_lower_field <= wr_byte;
				TFR_REMOTE_OVERHEAT: remote_overheat_field <= wr_byte;
				TFR_REMOTE_CRITICAL: remote_critical_field <= wr_byte;
				default: local_upper_field <= local_upper_field;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			passive_cooling_field <= TFR_RST_PASSIVE;
		end else if (wr_strobe && pointer == TFR_PASSIVE_COOLING) begin
			passive_cooling_field <= wr_byte[TFR_PASSIVE_BITS-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			target_period <= {TFR_RST_TARGET_BYTE, TFR_RST_TARGET_BYTE};
		end else if (wr_strobe && pointer == TFR_TARGET_PERIOD_LOW) begin
			target_period[7:0] <= wr_byte;
		end else if (wr_strobe && pointer == TFR_TARGET_PERIOD_HIGH) begin
			target_period[15:8] <= wr_byte;
		end
	end

	// passive threshold as a positive 11-bit value: weights 8..3 only
	assign passive_limit = {TFR_PASSIVE_TOP, passive_cooling_field, TFR_LOW_GAP, 1'b0};

	// period difference against target, on the held fan_period reading
	assign period_diff = (fan_period >= target_period) ? (fan_period - target_period) : (target_period - fan_period);
	assign next_settled = period_diff <= TFR_SETTLE_WINDOW;

	always_ff @(posedge mclk) begin
		if (srst) begin
			period_settled <= 1'b0;
		end else begin
			period_settled <= next_settled;
		end
	end

	// duty cycle handed to the fan driver
	always_ff @(posedge mclk) begin
		if (srst) begin
			duty_cycle <= TFR_RST_DUTY;
			fan_stopped <= 1'b0;
		end else if (auto_temp_mode && $signed(active_temp) <= $signed(passive_limit)) begin
			duty_cycle <= TFR_RST_DUTY;
			fan_stopped <= 1'b1;
		end else if (duty_req_valid && !(soft_speed_mode && next_settled)) begin
			duty_cycle <= duty_req;
			fan_stopped <= 1'b0;
		end else begin
			fan_stopped <= 1'b0;
		end
	end

endmodule : tfr_regs

// ===== test/tfr_host.sv
// Purpose: serial management bus host that reads and writes device registers
// Assumes: open-drain data wire resolved in the bench, scl driven by this host only
// Notes: each bus phase lasts HALF mclk cycles, scl idles high between frames
module tfr_host #(
	parameter int HALF = 10
) (
	input wire logic mclk,
	input wire logic sda_w,
	output logic scl,
	output logic sda
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	task automatic tick();
		repeat (HALF) @(negedge mclk);
	endtask : tick

	// lvl 1 gives a start, lvl 0 a stop
	task automatic edge_cond(input logic lvl);
		scl = 1'b0;
		tick();
		sda = lvl;
		tick();
		scl = 1'b1;
		tick();
		sda = ~lvl;
		tick();
	endtask : edge_cond

	task automatic bit_io(input logic b, output logic r);
		scl = 1'b0;
		tick();
		sda = b;
		tick();
		scl = 1'b1;
		tick();
		r = sda_w;
	endtask : bit_io

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : xfer

	task automatic wr(input logic [6:0] addr, input logic [7:0] ptr, input logic [7:0] d, output logic ok);
		logic [7:0] rx;
		logic a0, a1, a2;
		edge_cond(1'b1);
		xfer({addr, 1'b0}, rx, a0);
		xfer(ptr, rx, a1);
		xfer(d, rx, a2);
		edge_cond(1'b0);
		ok = a0 & a1 & a2;
	endtask : wr

	task automatic rd(input logic [6:0] addr, input logic [7:0] ptr, output logic [7:0] d, output logic ok);
		logic [7:0] rx;
		logic a0, a1, a2, a3;
		edge_cond(1'b1);
		xfer({addr, 1'b0}, rx, a0);
		xfer(ptr, rx, a1);
		edge_cond(1'b1);
		xfer({addr, 1'b1}, rx, a2);
		xfer(8'hFF, d, a3);
		edge_cond(1'b0);
		ok = a0 & a1 & a2;
	endtask : rd
endmodule : tfr_host

// ===== test/tfr_regs_asserts.sv
// Purpose: port-level checks of duty forcing, dead band and limit registers
// Assumes: one mclk domain, srst synchronous active high
// Notes: bound to the register bank from the bench top
module tfr_regs_asserts (
	input wire logic mclk,
	input wire logic srst,
	input wire logic scl_in,
	input wire logic period_valid,
	input wire logic auto_temp_mode,
	input wire logic soft_speed_mode,
	input wire logic [10:0] active_temp,
	input wire logic duty_req_valid,
	input wire logic [7:0] duty_req,
	input wire logic [7:0] duty_cycle,
	input wire logic fan_stopped,
	input wire logic period_settled,
	input wire logic [7:0] local_upper_field,
	input wire logic [7:0] local_lower_field,
	input wire logic [7:0] local_overheat_field,
	input wire logic [7:0] local_critical_field,
	input wire logic [7:0] remote_upper_field,
	input wire logic [7:0] remote_lower_field,
	input wire logic [7:0] remote_overheat_field,
	input wire logic [7:0] remote_critical_field,
	input wire logic [5:0] passive_cooling_field,
	input wire logic [15:0] target_period
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	sequence s_settled_req;
		soft_speed_mode && !auto_temp_mode && duty_req_valid && period_settled;
	endsequence
	sequence s_period_quiet;
		$past(period_settled) && !$past(period_valid) && $stable(target_period);
	endsequence

	a_forced_zero: assert property (
		auto_temp_mode && ($signed(active_temp) <= $signed({2'h0, passive_cooling_field, 3'h0}))
		|=> duty_cycle == 8'h00 && fan_stopped) else $error("duty not forced to zero");
	a_stopped_clear: assert property (
		!auto_temp_mode |=> !fan_stopped) else $error("fan stop without automatic loop");
	a_duty_loads: assert property (
		!auto_temp_mode && !soft_speed_mode && duty_req_valid |=> duty_cycle == $past(duty_req))
		else $error("requested duty not loaded");
	a_duty_idle_hold: assert property (
		!auto_temp_mode && !duty_req_valid |=> $stable(duty_cycle)) else $error("duty moved without request");
	a_dead_band_hold: assert property (
		s_settled_req ##0 s_period_quiet |=> $stable(duty_cycle)) else $error("duty adjusted inside dead band");
	a_local_limit_rst: assert property (
		$past(srst) |-> local_upper_field == 8'h3C && local_lower_field == 8'h00
		&& local_overheat_field == 8'h46 && local_critical_field == 8'h50) else $error("local limit reset value");
	a_remote_limit_rst: assert property (
		$past(srst) |-> remote_upper_field == 8'h50 && remote_lower_field == 8'h00
		&& remote_overheat_field == 8'h64 && remote_critical_field == 8'h69) else $error("remote limit reset value");
	a_target_rst: assert property (
		$past(srst) |-> target_period == 16'hFFFF && passive_cooling_field == 6'h00)
		else $error("target or passive reset value");
	a_write_scl_low: assert property (
		$changed({local_upper_field, remote_upper_field, passive_cooling_field, target_period})
		|-> !scl_in && !$past(scl_in, 2)) else $error("register changed outside a write slot");
endmodule : tfr_regs_asserts

// ===== test/test_tfr_regs.sv
// Purpose: self-checking bench for the temperature and fan reading register bank
// Assumes: host model drives the bus, bench drives core inputs on falling mclk
// Notes: one bus bit spans 30 mclk
module test_tfr_regs;
	import tfr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [6:0] DEV_ADDR = 7'h2C; // arbitrary
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic scl, host_sda, sda_out, sda_oe, sda_w, fan_stopped, period_settled;
	logic conv_valid = 1'b0, period_valid = 1'b0, duty_req_valid = 1'b0;
	logic auto_temp_mode = 1'b0, soft_speed_mode = 1'b0;
	logic [10:0] local_reading = '0, remote_reading = '0, active_temp = '0;
	logic [15:0] period_count = '0, target_period;
	logic [7:0] duty_req = '0, duty_cycle, lu, ll, lo, lc, ru, rl, ro, rc;
	logic [5:0] passive_cooling_field;
	int err_count = 0, total_checks = 0;

	always #2 mclk = ~mclk;
	assign sda_w = host_sda & (sda_oe ? sda_out : 1'b1);

	tfr_regs #(.BUS_ADDR(DEV_ADDR)) tfr_regs_inst (.mclk(mclk), .srst(srst), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .conv_valid(conv_valid), .local_reading(local_reading),
		.remote_reading(remote_reading), .period_valid(period_valid), .period_count(period_count),
		.auto_temp_mode(auto_temp_mode), .soft_speed_mode(soft_speed_mode), .active_temp(active_temp),
		.duty_req_valid(duty_req_valid), .duty_req(duty_req), .duty_cycle(duty_cycle), .fan_stopped(fan_stopped),
		.period_settled(period_settled), .local_upper_field(lu), .local_lower_field(ll), .local_overheat_field(lo),
		.local_critical_field(lc), .remote_upper_field(ru), .remote_lower_field(rl), .remote_overheat_field(ro),
		.remote_critical_field(rc), .passive_cooling_field(passive_cooling_field), .target_period(target_period));
	tfr_host tfr_host_inst (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda(host_sda));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic reg_rd(input logic [7:0] ptr, input logic [7:0] exp, input string what);
		logic [7:0] d;
		logic ok;
		tfr_host_inst.rd(DEV_ADDR, ptr, d, ok);
		chk("read ack", 16'h1, {15'h0, ok});
		chk(what, {8'h0, exp}, {8'h0, d});
	endtask : reg_rd

	task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d);
		logic ok;
		tfr_host_inst.wr(DEV_ADDR, ptr, d, ok);
		chk("write ack", 16'h1, {15'h0, ok});
	endtask : reg_wr

	task automatic do_reset();
		srst = 1'b1;
		repeat (16) @(negedge mclk);
		srst = 1'b0;
		repeat (8) @(negedge mclk);
	endtask : do_reset

	task automatic pulse_conv(input logic [10:0] l, input logic [10:0] r);
		@(negedge mclk);
		local_reading = l;
		remote_reading = r;
		conv_valid = 1'b1;
		@(negedge mclk);
		conv_valid = 1'b0;
	endtask : pulse_conv

	task automatic pulse_period(input logic [15:0] p);
		@(negedge mclk);
		period_count = p;
		period_valid = 1'b1;
		@(negedge mclk);
		period_valid = 1'b0;
	endtask : pulse_period

	task automatic set_duty(input logic at, input logic ss, input logic [10:0] t, input logic [7:0] d);
		@(negedge mclk);
		auto_temp_mode = at;
		soft_speed_mode = ss;
		active_temp = t;
		duty_req = d;
		duty_req_valid = 1'b1;
		@(negedge mclk);
		duty_req_valid = 1'b0;
	endtask : set_duty

	task automatic t_reset_values();
		logic [7:0] p [17] = '{8'h06, 8'h0A, 8'h0B, 8'h08, 8'h09, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1A, 8'h1B,
			8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h07};
		logic [7:0] e [17] = '{8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h3C, 8'h00, 8'h46, 8'h50, 8'h00, 8'h64, 8'h50,
			8'h00, 8'h69, 8'hFF, 8'hFF, 8'h00};
		foreach (p[i]) reg_rd(p[i], e[i], "reset value");
	endtask : t_reset_values

	task automatic t_limits();
		logic [7:0] p [11] = '{8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F};
		logic ok;
		foreach (p[i]) reg_wr(p[i], p[i] ^ 8'hC3);
		foreach (p[i]) reg_rd(p[i], (p[i] == 8'h1C) ? 8'h1F : p[i] ^ 8'hC3, "readback");
		chk("upper field", 16'h00D7, {8'h0, lu});
		chk("local lower and remote critical", 16'hD6DE, {ll, rc});
		chk("local overheat and critical", 16'hD5D8, {lo, lc});
		chk("remote upper and lower", 16'hDBDA, {ru, rl});
		chk("remote overheat", 16'h00D9, {8'h0, ro});
		chk("passive field", 16'h001F, {10'h0, passive_cooling_field});
		chk("target", 16'hDCDD, target_period);
		reg_wr(TFR_REMOTE_TEMP_HIGH, 8'h11);
		reg_rd(TFR_REMOTE_TEMP_HIGH, 8'h80, "read-only high");
		tfr_host_inst.wr(DEV_ADDR ^ 7'h01, TFR_LOCAL_UPPER_BOUND, 8'h00, ok);
		chk("foreign address ack", 16'h0, {15'h0, ok});
		chk("upper kept", 16'h00D7, {8'h0, lu});
		do_reset();
		chk("upper after reset", 16'h003C, {8'h0, lu});
		chk("target after reset", 16'hFFFF, target_period);
	endtask : t_limits

	task automatic t_temp_freeze();
		pulse_conv(11'h5A3, 11'h7F9);
		reg_rd(TFR_LOCAL_TEMP_HIGH, 8'hB4, "local high");
		pulse_conv(11'h123, 11'h456);
		reg_rd(TFR_REMOTE_TEMP_HIGH, 8'h8A, "remote high alone");
		reg_rd(TFR_TEMP_LOW_BITS, 8'h66, "low bits");
		pulse_conv(11'h7F9, 11'h008);
		reg_rd(TFR_LOCAL_TEMP_HIGH, 8'h24, "frozen local");
		reg_rd(TFR_REMOTE_TEMP_HIGH, 8'h8A, "frozen remote");
		reg_rd(TFR_LOCAL_TEMP_HIGH, 8'hFF, "released local");
		reg_rd(TFR_TEMP_LOW_BITS, 8'h20, "released low");
		reg_rd(TFR_REMOTE_TEMP_HIGH, 8'h01, "released remote");
	endtask : t_temp_freeze

	task automatic t_fan_freeze();
		pulse_period(16'h1234);
		reg_rd(TFR_FAN_PERIOD_LOW, 8'h34, "period low");
		pulse_period(16'hABCD);
		reg_rd(TFR_FAN_PERIOD_HIGH, 8'h12, "frozen period high");
		reg_rd(TFR_FAN_PERIOD_HIGH, 8'hAB, "released period high");
	endtask : t_fan_freeze

	task automatic t_duty();
		reg_wr(TFR_PASSIVE_COOLING, 8'h05);
		reg_wr(TFR_TARGET_PERIOD_HIGH, 8'hAB);
		reg_wr(TFR_TARGET_PERIOD_LOW, 8'hC3);
		set_duty(1'b1, 1'b0, 11'h028, 8'h80);
		chk("duty at threshold", 16'h0, {8'h0, duty_cycle});
		chk("fan stopped", 16'h1, {15'h0, fan_stopped});
		set_duty(1'b1, 1'b0, 11'h029, 8'h80);
		chk("duty above threshold", 16'h80, {8'h0, duty_cycle});
		chk("fan running", 16'h0, {15'h0, fan_stopped});
		set_duty(1'b1, 1'b0, 11'h7F0, 8'h90);
		chk("duty below zero", 16'h0, {8'h0, duty_cycle});
		set_duty(1'b0, 1'b0, 11'h000, 8'h80);
		chk("period settled", 16'h1, {15'h0, period_settled});
		set_duty(1'b0, 1'b1, 11'h000, 8'h40);
		chk("duty held", 16'h80, {8'h0, duty_cycle});
		pulse_period(16'hABCE);
		repeat (2) @(negedge mclk);
		chk("period unsettled", 16'h0, {15'h0, period_settled});
		set_duty(1'b0, 1'b1, 11'h000, 8'h40);
		chk("duty adjusted", 16'h40, {8'h0, duty_cycle});
	endtask : t_duty

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	initial begin
		repeat (100000) @(posedge mclk);
		err_count++;
		stop_test();
	end

	initial begin
		do_reset();
		t_reset_values();
		t_limits();
		t_temp_freeze();
		t_fan_freeze();
		t_duty();
		stop_test();
	end
endmodule : test_tfr_regs

bind tfr_regs tfr_regs_asserts tfr_regs_asserts_inst (.mclk(mclk), .srst(srst), .scl_in(scl_in),
	.period_valid(period_valid), .auto_temp_mode(auto_temp_mode), .soft_speed_mode(soft_speed_mode),
	.active_temp(active_temp), .duty_req_valid(duty_req_valid), .duty_req(duty_req), .duty_cycle(duty_cycle),
	.fan_stopped(fan_stopped), .period_settled(period_settled), .local_upper_field(local_upper_field),
	.local_lower_field(local_lower_field), .local_overheat_field(local_overheat_field),
	.local_critical_field(local_critical_field), .remote_upper_field(remote_upper_field),
	.remote_lower_field(remote_lower_field), .remote_overheat_field(remote_overheat_field),
	.remote_critical_field(remote_critical_field), .passive_cooling_field(passive_cooling_field),
	.target_period(target_period));
